// ### src/afd_datapath.sv
/*
 * Address and flag datapath: holds the 16-bit flag word, updates it from
 * arithmetic results, decides trap and interrupt acceptance, gives the
 * string step, and forms effective and 20-bit physical addresses.
 * Assumes the sequencer presents one request per strobe on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module afd_datapath
	import afd_pkg::*;
(
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	// Flag word direct write
	input  wire logic               flag_wr,
	input  wire logic [15:0]        flag_wdata,
	// Arithmetic result update
	input  wire logic               alu_go,
	input  wire afd_pkg::afd_op_t   alu_op,
	input  wire logic               alu_word,
	input  wire logic [15:0]        alu_a,
	input  wire logic [15:0]        alu_b,
	// Instruction boundary and interrupt request
	input  wire logic               instr_end,
	input  wire logic               intr_req,
	// Address request
	input  wire logic               ag_go,
	input  wire afd_pkg::afd_acc_t  ag_acc,
	input  wire afd_pkg::afd_mode_t ag_mode,
	input  wire afd_pkg::afd_reg_t  ag_ind_reg,
	input  wire logic               ag_base_frm,
	input  wire logic               ag_idx_dst,
	input  wire logic               ag_disp_byte,
	input  wire logic [15:0]        ag_disp,
	input  wire logic               ag_ovr_en,
	input  wire afd_pkg::afd_seg_t  ag_ovr_seg,
	input  wire logic               ag_elem_word,
	// Register values
	input  wire logic [15:0]        base_reg_b,
	input  wire logic [15:0]        frame_base_reg,
	input  wire logic [15:0]        src_index_reg,
	input  wire logic [15:0]        dest_index_reg,
	input  wire logic [15:0]        code_segment_reg,
	input  wire logic [15:0]        stack_segment_reg,
	input  wire logic [15:0]        data_segment_reg,
	input  wire logic [15:0]        extra_segment_reg,
	// Flag word and results
	output logic [15:0]             processor_flag_word,
	output logic [15:0]             alu_result_r,
	output logic                    step_trap_r,
	output logic                    intr_take_r,
	output logic [15:0]             index_step_r,
	// Address results
	output logic                    ag_valid_r,
	output logic [15:0]             eff_addr_r,
	output logic [19:0]             phys_addr_r,
	output afd_pkg::afd_seg_t       seg_used_r
);
	import afd_pkg::*;

	logic [15:0]  flags_r;
	logic [15:0]  flags_nxt;
	logic [15:0]  calc_res;
	logic [5:0]   calc_flg;
	logic         step_armed_r;
	afd_state_t   ag_state_r;
	logic [15:0]  ea_nxt;
	afd_seg_t     seg_nxt;
	logic [15:0]  seg_val;

	// Sign-extends a byte displacement, else passes the word
	function automatic logic [15:0] afd_disp(input logic byt, input logic [15:0] d);
		afd_disp = byt ? {{AFD_BYTE_W{d[7]}}, d[7:0]} : d;
	endfunction

	// Picks one of the four offset registers
	function automatic logic [15:0] afd_pick(input afd_reg_t r, input logic [15:0] s,
		input logic [15:0] di, input logic [15:0] b, input logic [15:0] f);
		unique case (r)
			AFD_R_SRC:  afd_pick = s;
			AFD_R_DST:  afd_pick = di;
			AFD_R_BASE: afd_pick = b;
			AFD_R_FRM:  afd_pick = f;
		endcase
	endfunction

	// ==========================================================
	// Flag computation
	afd_flag_calc u_calc (
		.op_a        (alu_a),
		.op_b        (alu_b),
		.carry_in    (1'b0),
		.op_sel      (alu_op),
		.word_op     (alu_word),
		.result      (calc_res),
		.arith_flags (calc_flg)
	);

	// Next flag word; the trap clear outranks a simultaneous load
	always_comb
	begin
		flags_nxt = flags_r;
		if (flag_wr)
			flags_nxt = flag_wdata;
		if (alu_go)
		begin
			flags_nxt[AFD_CARRY_BIT]  = calc_flg[0];
			flags_nxt[AFD_PARITY_BIT] = calc_flg[1];
			flags_nxt[AFD_AUX_BIT]    = calc_flg[2];
			flags_nxt[AFD_ZERO_BIT]   = calc_flg[3];
			flags_nxt[AFD_SIGN_BIT]   = calc_flg[4];
			flags_nxt[AFD_OVF_BIT]    = calc_flg[5];
		end
		if (instr_end && step_armed_r)
			flags_nxt[AFD_TRAP_BIT] = 1'b0;
		flags_nxt = (flags_nxt & AFD_FLAG_MASK) | (AFD_FIXED_VAL & ~AFD_FLAG_MASK);
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			flags_r <= AFD_FLAG_RST;
		else
			flags_r <= flags_nxt;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			alu_result_r <= 16'h0000;
		else if (alu_go)
			alu_result_r <= calc_res;
	end

	// ==========================================================
	// Trap and interrupt decisions at instruction boundaries
	// The trap is armed at one boundary so it fires after the next one
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step_armed_r <= 1'b0;
			step_trap_r  <= 1'b0;
			intr_take_r  <= 1'b0;
		end
		else
		begin
			step_trap_r  <= instr_end & step_armed_r;
			if (instr_end)
				step_armed_r <= flags_r[AFD_TRAP_BIT] & ~step_armed_r;
			intr_take_r  <= instr_end & intr_req & flags_r[AFD_IEN_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			index_step_r <= 16'h0000;
		else if (flags_r[AFD_DIR_BIT])
			index_step_r <= ag_elem_word ? -AFD_TWO : -AFD_ONE;
		else
			index_step_r <= ag_elem_word ? AFD_TWO : AFD_ONE;
	end

	// ==========================================================
	// Effective address and segment choice
	always_comb
	begin
		ea_nxt  = 16'h0000;
		seg_nxt = AFD_SEG_DATA;
		seg_val = data_segment_reg;
		unique case (ag_mode)
			AFD_AM_DIRECT:   ea_nxt = afd_disp(ag_disp_byte, ag_disp);
			AFD_AM_INDIRECT: ea_nxt = afd_pick(ag_ind_reg, src_index_reg, dest_index_reg,
				base_reg_b, frame_base_reg);
			AFD_AM_BASED:    ea_nxt = (ag_base_frm ? frame_base_reg : base_reg_b)
				+ afd_disp(ag_disp_byte, ag_disp);
			AFD_AM_INDEXED:  ea_nxt = (ag_idx_dst ? dest_index_reg : src_index_reg)
				+ afd_disp(ag_disp_byte, ag_disp);
			AFD_AM_BIDX:     ea_nxt = (ag_base_frm ? frame_base_reg : base_reg_b)
				+ (ag_idx_dst ? dest_index_reg : src_index_reg);
			AFD_AM_BIDX_D:   ea_nxt = (ag_base_frm ? frame_base_reg : base_reg_b)
				+ (ag_idx_dst ? dest_index_reg : src_index_reg)
				+ afd_disp(ag_disp_byte, ag_disp);
			default:         ea_nxt = 16'h0000;
		endcase
		// For data accesses, frame base as base register selects the stack segment when the mode uses a base term
		unique case (ag_acc)
			AFD_ACC_FETCH:  seg_nxt = AFD_SEG_CODE;
			AFD_ACC_STACK:  seg_nxt = AFD_SEG_STACK;
			AFD_ACC_STRDST: seg_nxt = AFD_SEG_EXTRA;
			AFD_ACC_DATA:   seg_nxt = ((ag_mode == AFD_AM_INDIRECT && ag_ind_reg == AFD_R_FRM)
				|| (ag_base_frm && (ag_mode == AFD_AM_BASED || ag_mode == AFD_AM_BIDX
				|| ag_mode == AFD_AM_BIDX_D))) ? AFD_SEG_STACK : AFD_SEG_DATA;
		endcase
		// override on memory operands; prefetch is never overridden
		if (ag_ovr_en && ag_acc != AFD_ACC_FETCH)
			seg_nxt = ag_ovr_seg;
		unique case (seg_nxt)
			AFD_SEG_EXTRA: seg_val = extra_segment_reg;
			AFD_SEG_CODE:  seg_val = code_segment_reg;
			AFD_SEG_STACK: seg_val = stack_segment_reg;
			AFD_SEG_DATA:  seg_val = data_segment_reg;
		endcase
	end

	// Address result registers, one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ag_state_r  <= AFD_ST_IDLE;
			eff_addr_r  <= 16'h0000;
			phys_addr_r <= 20'h00000;
			seg_used_r  <= AFD_SEG_DATA;
		end
		else if (ag_go)
		begin
			ag_state_r  <= AFD_ST_DONE;
			eff_addr_r  <= ea_nxt;
			seg_used_r  <= seg_nxt;
			phys_addr_r <= {seg_val, {AFD_SEG_SHIFT{1'b0}}} + {{AFD_SEG_SHIFT{1'b0}}, ea_nxt};
		end
		else
			ag_state_r  <= AFD_ST_IDLE;
	end

	always_comb
	begin
		processor_flag_word = flags_r;
		ag_valid_r          = (ag_state_r == AFD_ST_DONE);
	end

	// ==========================================================
	// Checks
	// Physical address rebuilt from the chosen segment input and the offset output
	property p_phys;
		@(posedge sys_clk) disable iff (!rst_b)
		ag_go |=> phys_addr_r == ({(seg_used_r == AFD_SEG_CODE) ? $past(code_segment_reg) :
			(seg_used_r == AFD_SEG_STACK) ? $past(stack_segment_reg) :
			(seg_used_r == AFD_SEG_EXTRA) ? $past(extra_segment_reg) : $past(data_segment_reg),
			4'h0} + {4'h0, eff_addr_r});
	endproperty
	a_phys: assert property (p_phys) else $error("phys addr wrong");
	property p_zero;
		@(posedge sys_clk) disable iff (!rst_b)
		alu_go |=> flags_r[AFD_ZERO_BIT] == (alu_result_r == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_fixed;
		@(posedge sys_clk) disable iff (!rst_b)
		flag_wr |=> (flags_r & ~AFD_FLAG_MASK) == (AFD_FIXED_VAL & ~AFD_FLAG_MASK);
	endproperty
	a_fixed: assert property (p_fixed) else $error("reserved bits moved");
	property p_intr;
		@(posedge sys_clk) disable iff (!rst_b)
		intr_take_r |-> $past(instr_end) && $past(flags_r[AFD_IEN_BIT]) && $past(intr_req);
	endproperty
	a_intr: assert property (p_intr) else $error("masked interrupt taken");
	property p_trap;
		@(posedge sys_clk) disable iff (!rst_b)
		step_trap_r |-> !flags_r[AFD_TRAP_BIT];
	endproperty
	a_trap: assert property (p_trap) else $error("trap not cleared");
	property p_code;
		@(posedge sys_clk) disable iff (!rst_b)
		ag_go && ag_acc == AFD_ACC_FETCH |=> seg_used_r == AFD_SEG_CODE;
	endproperty
	a_code: assert property (p_code) else $error("fetch not code");
	property p_extra;
		@(posedge sys_clk) disable iff (!rst_b)
		ag_go && ag_acc == AFD_ACC_STRDST && !ag_ovr_en |=> seg_used_r == AFD_SEG_EXTRA;
	endproperty
	a_extra: assert property (p_extra) else $error("string dest not extra");
	property p_direct;
		@(posedge sys_clk) disable iff (!rst_b)
		ag_go && ag_mode == AFD_AM_DIRECT && ag_disp_byte |=>
			eff_addr_r == {{8{$past(ag_disp[7])}}, $past(ag_disp[7:0])};
	endproperty
	a_direct: assert property (p_direct) else $error("direct sext wrong");
	property p_dir;
		@(posedge sys_clk) disable iff (!rst_b)
		flags_r[AFD_DIR_BIT] && $stable(flags_r[AFD_DIR_BIT]) |=> index_step_r[15];
	endproperty
	a_dir: assert property (p_dir) else $error("direction step wrong");
	c_trap: cover property (@(posedge sys_clk) step_trap_r);
	c_intr: cover property (@(posedge sys_clk) intr_take_r);
	c_ovr:  cover property (@(posedge sys_clk) ag_go && ag_ovr_en);
endmodule
`default_nettype wire

// ### src/afd_pkg.sv
/*
 * Package for the address and flag datapath: flag word layout, reset
 * value, addressing-mode and segment-select encodings, operation codes.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package afd_pkg;
	// ==========================================================
	// Flag word layout
	localparam int          AFD_FLAG_W     = 16;
	localparam int          AFD_CARRY_BIT  = 0;
	localparam int          AFD_PARITY_BIT = 2;
	localparam int          AFD_AUX_BIT    = 4;
	localparam int          AFD_ZERO_BIT   = 6;
	localparam int          AFD_SIGN_BIT   = 7;
	localparam int          AFD_TRAP_BIT   = 8;
	localparam int          AFD_IEN_BIT    = 9;
	localparam int          AFD_DIR_BIT    = 10;
	localparam int          AFD_OVF_BIT    = 11;
	// Bits holding a defined flag; all others are fixed
	localparam logic [15:0] AFD_FLAG_MASK  = 16'h0FD5;
	// Value shown in the undefined positions
	localparam logic [15:0] AFD_FIXED_VAL  = 16'h0000;
	localparam logic [15:0] AFD_FLAG_RST   = 16'h0000;

	// ==========================================================
	// Address widths
	localparam int          AFD_OFS_W      = 16;
	localparam int          AFD_PHYS_W     = 20;
	localparam int          AFD_SEG_SHIFT  = 4;
	localparam int          AFD_NIB_W      = 4;
	localparam int          AFD_BYTE_W     = 8;
	localparam logic [15:0] AFD_ONE        = 16'h0001;
	localparam logic [15:0] AFD_TWO        = 16'h0002;

	// ==========================================================
	// Operation selector for the flag unit
	typedef enum logic [1:0] {
		AFD_OP_ADD = 2'h0,
		AFD_OP_SUB = 2'h1,
		AFD_OP_LOG = 2'h2
	} afd_op_t;

	// Memory addressing mode
	typedef enum logic [2:0] {
		AFD_AM_DIRECT   = 3'h0,
		AFD_AM_INDIRECT = 3'h1,
		AFD_AM_BASED    = 3'h2,
		AFD_AM_INDEXED  = 3'h3,
		AFD_AM_BIDX     = 3'h4,
		AFD_AM_BIDX_D   = 3'h5
	} afd_mode_t;

	// Register picks: indirect chooses one of four, base and index of two
	typedef enum logic [1:0] {
		AFD_R_SRC  = 2'h0,
		AFD_R_DST  = 2'h1,
		AFD_R_BASE = 2'h2,
		AFD_R_FRM  = 2'h3
	} afd_reg_t;

	// Segment register select
	typedef enum logic [1:0] {
		AFD_SEG_EXTRA = 2'h0,
		AFD_SEG_CODE  = 2'h1,
		AFD_SEG_STACK = 2'h2,
		AFD_SEG_DATA  = 2'h3
	} afd_seg_t;

	// Kind of access requested
	typedef enum logic [1:0] {
		AFD_ACC_FETCH  = 2'h0,
		AFD_ACC_STACK  = 2'h1,
		AFD_ACC_STRDST = 2'h2,
		AFD_ACC_DATA   = 2'h3
	} afd_acc_t;

	// Address generator pipeline state
	typedef enum logic [1:0] {
		AFD_ST_IDLE = 2'b01,
		AFD_ST_DONE = 2'b10
	} afd_state_t;
endpackage

// ### src/afd_flag_calc.sv
/*
 * Combinational flag calculator: carry, parity, auxiliary carry, zero,
 * sign and overflow of an add, subtract or logical result, byte or word.
 * Assumes operands are stable in the cycle the parent samples them.
 */
`timescale 1ns/10ps
`default_nettype none
module afd_flag_calc
	import afd_pkg::*;
(
	// Operands
	input  wire logic [15:0]   op_a,
	input  wire logic [15:0]   op_b,
	input  wire logic          carry_in,
	input  wire afd_pkg::afd_op_t op_sel,
	input  wire logic          word_op,
	// Results
	output logic [15:0]        result,
	output logic [5:0]         arith_flags
);
	import afd_pkg::*;

	logic [16:0] sum_w;
	logic [4:0]  nib;
	logic        msb_c;
	logic        sgn;
	logic        ovf;
	logic [15:0] res;

	// ==========================================================
	// Adder with byte or word carry point
	always_comb
	begin
		sum_w = 17'h00000;
		nib   = 5'h00;
		res   = 16'h0000;
		msb_c = 1'b0;
		ovf   = 1'b0;
		unique case (op_sel)
			AFD_OP_ADD:
			begin
				sum_w = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, carry_in};
				nib   = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
			end
			AFD_OP_SUB:
			begin
				sum_w = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, carry_in};
				nib   = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in};
			end
			default:
			begin
				sum_w = {1'b0, op_a & op_b};
			end
		endcase
		res = sum_w[15:0];
		if (op_sel != AFD_OP_LOG)
		begin
			msb_c = word_op ? sum_w[16] : (sum_w[8] ^ op_a[8] ^ op_b[8]);
			if (word_op)
				ovf = (op_a[15] ^ res[15]) & ~(op_a[15] ^ op_b[15] ^ (op_sel == AFD_OP_SUB));
			else
				ovf = (op_a[7] ^ res[7]) & ~(op_a[7] ^ op_b[7] ^ (op_sel == AFD_OP_SUB));
		end
	end

	// ==========================================================
	// Flags packed as {ovf, sign, zero, aux, parity, carry}
	always_comb
	begin
		sgn    = word_op ? res[15] : res[7];
		result = word_op ? res : {8'h00, res[7:0]};
		arith_flags[0] = msb_c;
		// even count of ones in low byte
		arith_flags[1] = ~(^res[7:0]);
		arith_flags[2] = (op_sel != AFD_OP_LOG) & nib[4];
		arith_flags[3] = word_op ? (res == 16'h0000) : (res[7:0] == 8'h00);
		arith_flags[4] = sgn;
		arith_flags[5] = ovf;
	end
endmodule
`default_nettype wire

// ### tb/afd_datapath_test.sv
/*
 * Self-checking bench for the address and flag datapath: flag word,
 * arithmetic flags, trap and interrupt pulses, segment and offset forming.
 * Assumes only the design files and their embedded assertions.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, act, exp); end end
module afd_datapath_test;
	import afd_pkg::*;
	typedef struct packed {logic [15:0] fw; logic [15:0] res; logic [15:0] rm; logic [15:0] fm;} afd_fexp_t;
	typedef struct packed {logic [15:0] eff; logic [19:0] phys; afd_seg_t seg; logic [15:0] stp;
		logic [1:0] chk;} afd_aexp_t;
	// ==========================================================
	// Stimulus and observed signals
	logic        sys_clk = 1'b0, rst_b = 1'b0, flag_wr, alu_go, alu_word, instr_end, intr_req;
	logic        ag_go, ag_base_frm, ag_idx_dst, ag_disp_byte, ag_ovr_en, ag_elem_word;
	logic [15:0] flag_wdata, alu_a, alu_b, ag_disp, base_reg_b, frame_base_reg;
	logic [15:0] src_index_reg, dest_index_reg, code_segment_reg, stack_segment_reg;
	logic [15:0] data_segment_reg, extra_segment_reg;
	afd_op_t     alu_op;
	afd_acc_t    ag_acc;
	afd_mode_t   ag_mode;
	afd_reg_t    ag_ind_reg;
	afd_seg_t    ag_ovr_seg, seg_used_r;
	logic [15:0] processor_flag_word, alu_result_r, index_step_r, eff_addr_r;
	logic        step_trap_r, intr_take_r, ag_valid_r, fl_due;
	logic [19:0] phys_addr_r;
	int          error_cnt = 0, num_checks = 0;
	logic [15:0] rnd = 16'h0034, ctl;
	afd_fexp_t   fq[$], fe;
	afd_aexp_t   aq[$], ae;
	logic [1:0]  eq[$], ek;

	afd_datapath DUT (.sys_clk(sys_clk), .rst_b(rst_b), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
		.alu_go(alu_go), .alu_op(alu_op), .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b),
		.instr_end(instr_end), .intr_req(intr_req), .ag_go(ag_go), .ag_acc(ag_acc),
		.ag_mode(ag_mode), .ag_ind_reg(ag_ind_reg), .ag_base_frm(ag_base_frm),
		.ag_idx_dst(ag_idx_dst), .ag_disp_byte(ag_disp_byte), .ag_disp(ag_disp),
		.ag_ovr_en(ag_ovr_en), .ag_ovr_seg(ag_ovr_seg), .ag_elem_word(ag_elem_word),
		.base_reg_b(base_reg_b), .frame_base_reg(frame_base_reg), .src_index_reg(src_index_reg),
		.dest_index_reg(dest_index_reg), .code_segment_reg(code_segment_reg),
		.stack_segment_reg(stack_segment_reg), .data_segment_reg(data_segment_reg),
		.extra_segment_reg(extra_segment_reg), .processor_flag_word(processor_flag_word),
		.alu_result_r(alu_result_r), .step_trap_r(step_trap_r), .intr_take_r(intr_take_r),
		.index_step_r(index_step_r), .ag_valid_r(ag_valid_r), .eff_addr_r(eff_addr_r),
		.phys_addr_r(phys_addr_r), .seg_used_r(seg_used_r));

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	// ==========================================================
	// Helpers: random source and drivers
	function automatic logic [15:0] rv();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction

	// Flag write; only the control bits survive into later expectations
	task automatic fwr(input logic [15:0] v);
		ctl = v & 16'h0700;
		fq.push_back('{v & AFD_FLAG_MASK, 16'h0000, 16'h0000, 16'hFFFF});
		flag_wdata = v;
		flag_wr = 1'b1;
		@(negedge sys_clk);
		flag_wr = 1'b0;
		@(negedge sys_clk);
	endtask

	// Arithmetic request; leaves alu_go high so calls run back to back
	task automatic alu(input afd_op_t op, input logic w, input logic [15:0] a, input logic [15:0] b);
		logic [15:0] am, bm, f;
		logic [16:0] s;
		logic [4:0]  n;
		logic        sa, sb, sr, lg;
		lg = (op == AFD_OP_LOG);
		am = w ? a : {8'h00, a[7:0]};
		bm = w ? b : {8'h00, b[7:0]};
		n = (op == AFD_OP_SUB) ? {1'b0, am[3:0]} - {1'b0, bm[3:0]} : {1'b0, am[3:0]} + {1'b0, bm[3:0]};
		s = (op == AFD_OP_SUB) ? {1'b0, am} - {1'b0, bm} : {1'b0, am} + {1'b0, bm};
		if (lg)
			s = {1'b0, am & bm};
		sa = w ? am[15] : am[7];
		sb = w ? bm[15] : bm[7];
		sr = w ? s[15] : s[7];
		f = ctl;
		f[AFD_CARRY_BIT] = !lg && (w ? s[16] : s[8]);
		f[AFD_PARITY_BIT] = ~^s[7:0];
		f[AFD_AUX_BIT] = !lg && n[4];
		f[AFD_ZERO_BIT] = w ? (s[15:0] == 16'h0000) : (s[7:0] == 8'h00);
		f[AFD_SIGN_BIT] = sr;
		f[AFD_OVF_BIT] = (op == AFD_OP_ADD) ? (sa == sb && sr != sa) : (!lg && sa != sb && sr != sa);
		// A logical result has no carry, so aux carry must read clear as well
		fq.push_back('{f, s[15:0], {w ? 8'hFF : 8'h00, 8'hFF}, 16'hFFFF});
		alu_op = op;
		alu_word = w;
		alu_a = a;
		alu_b = b;
		alu_go = 1'b1;
		@(negedge sys_clk);
	endtask

	// Address request with random registers; leaves ag_go high
	task automatic agr(input afd_acc_t acc);
		logic [15:0] d, bs, ix, e, sv;
		logic        fr;
		afd_seg_t    sg;
		base_reg_b = rv();
		frame_base_reg = rv();
		src_index_reg = rv();
		dest_index_reg = rv();
		code_segment_reg = rv();
		stack_segment_reg = rv();
		data_segment_reg = rv();
		extra_segment_reg = rv();
		ag_disp = rv();
		d = rv();
		ag_mode = (acc == AFD_ACC_STRDST) ? AFD_AM_INDIRECT : afd_mode_t'(3'(d % 6));
		ag_ind_reg = (acc == AFD_ACC_STRDST) ? AFD_R_DST : afd_reg_t'(d[4:3]);
		{ag_base_frm, ag_idx_dst, ag_disp_byte, ag_elem_word} = d[8:5];
		ag_ovr_en = (acc == AFD_ACC_DATA) && d[9];
		ag_ovr_seg = afd_seg_t'(d[11:10]);
		ag_acc = acc;
		bs = ag_base_frm ? frame_base_reg : base_reg_b;
		ix = ag_idx_dst ? dest_index_reg : src_index_reg;
		d = ag_disp_byte ? {{8{ag_disp[7]}}, ag_disp[7:0]} : ag_disp;
		case (ag_mode)
			AFD_AM_DIRECT:   e = d;
			AFD_AM_INDIRECT: e = (ag_ind_reg == AFD_R_SRC) ? src_index_reg :
				(ag_ind_reg == AFD_R_DST) ? dest_index_reg :
				(ag_ind_reg == AFD_R_BASE) ? base_reg_b : frame_base_reg;
			AFD_AM_BASED:    e = bs + d;
			AFD_AM_INDEXED:  e = ix + d;
			AFD_AM_BIDX:     e = bs + ix;
			default:         e = bs + ix + d;
		endcase
		fr = (ag_mode inside {AFD_AM_BASED, AFD_AM_BIDX, AFD_AM_BIDX_D} && ag_base_frm) ||
			(ag_mode == AFD_AM_INDIRECT && ag_ind_reg == AFD_R_FRM);
		sg = (acc == AFD_ACC_FETCH) ? AFD_SEG_CODE : (acc == AFD_ACC_STACK) ? AFD_SEG_STACK :
			(acc == AFD_ACC_STRDST) ? AFD_SEG_EXTRA : ag_ovr_en ? ag_ovr_seg :
			fr ? AFD_SEG_STACK : AFD_SEG_DATA;
		sv = (sg == AFD_SEG_EXTRA) ? extra_segment_reg : (sg == AFD_SEG_CODE) ? code_segment_reg :
			(sg == AFD_SEG_STACK) ? stack_segment_reg : data_segment_reg;
		aq.push_back('{e, {sv, 4'h0} + {4'h0, e}, sg, ctl[AFD_DIR_BIT] ?
			(ag_elem_word ? 16'hFFFE : 16'hFFFF) : (ag_elem_word ? 16'h0002 : 16'h0001),
			{acc == AFD_ACC_STRDST, 1'b1}});
		ag_go = 1'b1;
		@(negedge sys_clk);
	endtask

	// One instruction boundary pulse
	task automatic ie();
		instr_end = 1'b1;
		@(negedge sys_clk);
		instr_end = 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic stop_test();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// Monitor: results are settled at the falling edge after the strobe
	always @(posedge sys_clk)
		fl_due <= (flag_wr | alu_go) & rst_b;

	always @(negedge sys_clk)
	begin
		if (fl_due === 1'b1)
		begin
			fe = fq.pop_front();
			`CHK(processor_flag_word & fe.fm, fe.fw & fe.fm)
			`CHK(alu_result_r & fe.rm, fe.res & fe.rm)
		end
		if (ag_valid_r === 1'b1)
		begin
			ae = aq.pop_front();
			`CHK(seg_used_r, ae.seg)
			if (ae.chk[0])
			begin
				`CHK(eff_addr_r, ae.eff)
				`CHK(phys_addr_r, ae.phys)
			end
			if (ae.chk[1])
				`CHK(index_step_r, ae.stp)
		end
		if (step_trap_r === 1'b1 || intr_take_r === 1'b1)
		begin
			ek = eq.pop_front();
			`CHK({step_trap_r, intr_take_r}, ek)
			if (step_trap_r === 1'b1)
				`CHK(processor_flag_word[AFD_TRAP_BIT], 1'b0)
		end
	end

	// Watchdog: the whole sequence needs well under 2000 cycles
	initial
	begin
		repeat (2000) @(posedge sys_clk);
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		{flag_wr, alu_go, alu_word, instr_end, intr_req, ag_go, ag_base_frm, ag_idx_dst} = '0;
		{ag_disp_byte, ag_ovr_en, ag_elem_word, flag_wdata, alu_a, alu_b, ag_disp} = '0;
		{base_reg_b, frame_base_reg, src_index_reg, dest_index_reg} = '0;
		{code_segment_reg, stack_segment_reg, data_segment_reg, extra_segment_reg} = '0;
		alu_op = AFD_OP_ADD;
		ag_acc = AFD_ACC_DATA;
		ag_mode = AFD_AM_DIRECT;
		ag_ind_reg = AFD_R_SRC;
		ag_ovr_seg = AFD_SEG_DATA;
		ctl = 16'h0000;
		repeat (5) @(negedge sys_clk);
		`CHK(processor_flag_word, AFD_FLAG_RST)
		`CHK(seg_used_r, AFD_SEG_DATA)
		rst_b = 1'b1;
		@(negedge sys_clk);
		// Undefined positions stay fixed; sets trap, enable and direction
		fwr(16'hFFFF);
		alu(AFD_OP_ADD, 1'b1, 16'hFFFF, 16'h0001);
		alu(AFD_OP_ADD, 1'b0, 16'hAB7F, 16'h0001);
		alu(AFD_OP_SUB, 1'b1, 16'h0000, 16'h0001);
		alu(AFD_OP_SUB, 1'b0, 16'h0080, 16'h0001);
		repeat (60) alu(afd_op_t'(2'(rv() % 3)), rnd[4], rv(), rv());
		alu_go = 1'b0;
		// Address requests back to back, direction set then clear
		repeat (40) agr(afd_acc_t'(rv() % 4));
		ag_go = 1'b0;
		fwr(16'h0000);
		repeat (40) agr(afd_acc_t'(rv() % 4));
		ag_go = 1'b0;
		// Trap steps once after the next instruction, then stays quiet
		fwr(16'h0100);
		ie();
		eq.push_back(2'b10);
		ie();
		ctl = 16'h0000;
		ie();
		// Maskable request ignored while disabled, taken once enabled
		intr_req = 1'b1;
		ie();
		fwr(16'h0200);
		eq.push_back(2'b01);
		ie();
		intr_req = 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK(fq.size() + aq.size() + eq.size(), 0)
		stop_test();
	end
endmodule
`default_nettype wire
